// ---- hdl/main_edge_input_front_pkg.sv ----
// Constants, register map and carrier types of the trigger source front end
package main_edge_input_front_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int N_BP   = 6;
    localparam int N_CH   = 4;
    localparam int SMP_W  = 16;
    localparam int N_PIN  = 2 + N_BP;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
    localparam logic [ADDR_W-1:0] REG_TERM      = 4'h1;
    localparam logic [ADDR_W-1:0] REG_THRESH    = 4'h2;
    localparam logic [ADDR_W-1:0] REG_BP_DIR    = 4'h3;
    localparam logic [ADDR_W-1:0] REG_BP_MASK   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_LVL_CTRL  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_LVL_CODE  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_LVL_RESET = 4'h7;
    localparam logic [ADDR_W-1:0] REG_PERIOD    = 4'h8;
    localparam logic [ADDR_W-1:0] REG_SW_MAIN_EDGE_INPUT   = 4'h9;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hA;
    localparam logic [ADDR_W-1:0] REG_COUNT     = 4'hB;

    // Field positions
    localparam int CTRL_SRC_LSB   = 0;
    localparam int CTRL_MAIN_FALL = 4;
    localparam int CTRL_SYNC_FALL = 5;
    localparam int CTRL_ARM       = 8;
    localparam int TERM_MAIN      = 0;
    localparam int TERM_SYNC      = 1;
    localparam int LVL_CH_LSB     = 0;
    localparam int LVL_FALL       = 4;
    localparam int SW_MAIN_EDGE_INPUT_BIT    = 0;
    localparam int STAT_PIN_LSB   = 8;
    localparam int STAT_LVL_ARMED = 4;
    localparam int STAT_BP_OR     = 5;

    // Reset values
    localparam logic [15:0]       THRESH_RESET_MV = 16'h01F4;
    localparam logic [DATA_W-1:0] PERIOD_RESET    = 32'h0000_0400;
    localparam logic [SMP_W-1:0]  LVL_CODE_RESET  = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_PS = 20000;
    localparam int MAIN_RES_PS   = 125;
    localparam int AUX_RES_PS    = 4000;
    localparam int AUX_RES_CYC_RAW = AUX_RES_PS / CLK_PERIOD_PS;
    localparam int AUX_RES_CYC   = (AUX_RES_CYC_RAW < 1) ? 1 : AUX_RES_CYC_RAW;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_SOFTWARE, SRC_MAIN, SRC_SYNC,
        SRC_BACKPLANE, SRC_LEVEL, SRC_PERIODIC
    } src_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed {
        logic                       valid;
        logic [N_CH-1:0][SMP_W-1:0] data;
    } sample_bus_type;
endpackage

// ---- hdl/main_edge_input_front_end.sv ----
// Trigger source front end: pin edges, backplane mask, level and periodic triggers
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module main_edge_input_front_end
    import main_edge_input_front_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    // Register port
    input  wire reg_req_type       reg_req_in,
    output logic [DATA_W-1:0]      rdata_out,
    // Front panel pins
    input  wire logic              main_edge_input_in,
    input  wire logic              sync_input_in,
    // Backplane lines: bus ports 0,1 then multipoint 17..20
    input  wire logic [N_BP-1:0]   bp_line_in,
    output logic [N_BP-1:0]        bp_line_out,
    output logic [N_BP-1:0]        bp_line_oe_out,
    // Sample data and output source level
    input  wire sample_bus_type    samples_in,
    input  wire logic              main_edge_input_out_level_in,
    // Acquisition engine side
    output logic                   trigger_pulse_out,
    output src_type                trigger_source_out,
    output logic                   backplane_trigger_out,
    // Analog front end settings
    output logic                   main_termination_out,
    output logic                   sync_termination_out,
    output logic [15:0]            threshold_mv_out
);

    // Configuration registers
    src_type                 src_sel;
    logic                    main_fall;
    logic                    sync_fall;
    logic                    arm;
    logic [N_BP-1:0]         bp_mask;
    logic [1:0]              lvl_ch;
    logic                    lvl_fall;
    logic signed [SMP_W-1:0] lvl_code;
    logic signed [SMP_W-1:0] lvl_reset;
    logic [DATA_W-1:0]       period;
    logic [DATA_W-1:0]       main_edge_input_count;

    logic wr_en;
    logic rd_en;
    assign wr_en = reg_req_in.wr;
    assign rd_en = reg_req_in.rd;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_sel   <= SRC_NONE;
            main_fall <= 1'b0;
            sync_fall <= 1'b0;
            arm       <= 1'b0;
        end else if (wr_en && reg_req_in.addr == REG_CTRL) begin
            src_sel   <= src_type'(reg_req_in.wdata[CTRL_SRC_LSB +: 3]);
            main_fall <= reg_req_in.wdata[CTRL_MAIN_FALL];
            sync_fall <= reg_req_in.wdata[CTRL_SYNC_FALL];
            arm       <= reg_req_in.wdata[CTRL_ARM];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            main_termination_out <= 1'b0;
            sync_termination_out <= 1'b0;
            threshold_mv_out     <= THRESH_RESET_MV;
        end else if (wr_en && reg_req_in.addr == REG_TERM) begin
            main_termination_out <= reg_req_in.wdata[TERM_MAIN];
            sync_termination_out <= reg_req_in.wdata[TERM_SYNC];
        end else if (wr_en && reg_req_in.addr == REG_THRESH) begin
            threshold_mv_out     <= reg_req_in.wdata[15:0];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bp_line_oe_out <= '0;
            bp_mask        <= '0;
        end else if (wr_en && reg_req_in.addr == REG_BP_DIR) begin
            bp_line_oe_out <= reg_req_in.wdata[N_BP-1:0];
        end else if (wr_en && reg_req_in.addr == REG_BP_MASK) begin
            bp_mask        <= reg_req_in.wdata[N_BP-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lvl_ch    <= 2'h0;
            lvl_fall  <= 1'b0;
            lvl_code  <= LVL_CODE_RESET;
            lvl_reset <= LVL_CODE_RESET;
            period    <= PERIOD_RESET;
        end else if (wr_en) begin
            unique case (reg_req_in.addr)
                REG_LVL_CTRL: begin
                    lvl_ch   <= reg_req_in.wdata[LVL_CH_LSB +: 2];
                    lvl_fall <= reg_req_in.wdata[LVL_FALL];
                end
                REG_LVL_CODE:  lvl_code  <= reg_req_in.wdata[SMP_W-1:0];
                REG_LVL_RESET: lvl_reset <= reg_req_in.wdata[SMP_W-1:0];
                REG_PERIOD:    period    <= reg_req_in.wdata;
                default: ;
            endcase
        end
    end

    logic sw_ev;
    assign sw_ev = wr_en && reg_req_in.addr == REG_SW_MAIN_EDGE_INPUT
                   && reg_req_in.wdata[SW_MAIN_EDGE_INPUT_BIT];

    // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
    logic [N_PIN-1:0] pin_raw;
    logic [N_PIN-1:0] s1;
    logic [N_PIN-1:0] s2;
    logic [N_PIN-1:0] s3;
    logic [N_PIN-1:0] pin_lvl;
    logic [N_PIN-1:0] next_pin_lvl;
    logic [N_PIN-1:0] pin_rise;
    logic [N_PIN-1:0] pin_fall;
    assign pin_raw = {bp_line_in, sync_input_in, main_edge_input_in};

    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi++) begin : g_pin
            assign next_pin_lvl[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pin_lvl[gi];
        end
    endgenerate

    // Every data clock cycle samples all pins, in 20 ns steps, coarser than the 4 ns aux resolution
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1       <= '0;
            s2       <= '0;
            s3       <= '0;
            pin_lvl  <= '0;
            pin_rise <= '0;
            pin_fall <= '0;
        end else begin
            s1       <= pin_raw;
            s2       <= s1;
            s3       <= s2;
            pin_lvl  <= next_pin_lvl;
            pin_rise <= next_pin_lvl & ~pin_lvl;
            pin_fall <= ~next_pin_lvl & pin_lvl;
        end
    end

    logic main_ev;
    logic sync_ev;
    assign main_ev = main_fall ? pin_fall[0] : pin_rise[0];
    assign sync_ev = sync_fall ? pin_fall[1] : pin_rise[1];

    // Backplane: masked OR of input-direction lines, output driven meanwhile
    logic [N_BP-1:0] bp_lvl;
    logic            bp_or;
    logic            bp_ev;
    assign bp_lvl = pin_lvl[N_PIN-1:2];
    assign bp_or  = |(bp_lvl & bp_mask & ~bp_line_oe_out);
    assign bp_ev  = bp_or && !backplane_trigger_out;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            backplane_trigger_out <= 1'b0;
            bp_line_out           <= '0;
        end else begin
            backplane_trigger_out <= bp_or;
            bp_line_out           <= {N_BP{main_edge_input_out_level_in}};
        end
    end

    // Level trigger with hysteresis
    logic signed [SMP_W-1:0] cur_smp;
    logic signed [SMP_W-1:0] prev_smp;
    logic                    prev_ok;
    logic                    lvl_armed;
    logic                    lvl_cross;
    logic                    rst_cross;
    logic                    lvl_ev;
    assign cur_smp = samples_in.data[lvl_ch];

    always_comb begin
        if (lvl_fall) begin
            lvl_cross = prev_smp > lvl_code && cur_smp <= lvl_code;
            rst_cross = cur_smp >= lvl_reset;
        end else begin
            lvl_cross = prev_smp < lvl_code && cur_smp >= lvl_code;
            rst_cross = cur_smp <= lvl_reset;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_smp  <= '0;
            prev_ok   <= 1'b0;
            lvl_armed <= 1'b1;
            lvl_ev    <= 1'b0;
        end else begin
            lvl_ev <= 1'b0;
            if (samples_in.valid) begin
                prev_smp <= cur_smp;
                prev_ok  <= 1'b1;
                if (lvl_armed && prev_ok && lvl_cross) begin
                    lvl_ev    <= 1'b1;
                    lvl_armed <= 1'b0;
                end else if (!lvl_armed && rst_cross) begin
                    lvl_armed <= 1'b1;
                end
            end
        end
    end

    // Periodic trigger counted in samples; a period of zero stops it
    logic [DATA_W-1:0] per_cnt;
    logic              per_ev;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            per_cnt <= '0;
            per_ev  <= 1'b0;
        end else begin
            per_ev <= 1'b0;
            if (period == '0) begin
                per_cnt <= '0;
            end else if (samples_in.valid) begin
                if (per_cnt >= period - 32'h0000_0001) begin
                    per_cnt <= '0;
                    per_ev  <= 1'b1;
                end else begin
                    per_cnt <= per_cnt + 32'h0000_0001;
                end
            end
        end
    end

    // Source selection and forwarding
    logic sel_ev;
    always_comb begin
        unique case (src_sel)
            SRC_SOFTWARE:  sel_ev = sw_ev;
            SRC_MAIN:      sel_ev = main_ev;
            SRC_SYNC:      sel_ev = sync_ev;
            SRC_BACKPLANE: sel_ev = bp_ev;
            SRC_LEVEL:     sel_ev = lvl_ev;
            SRC_PERIODIC:  sel_ev = per_ev;
            default:       sel_ev = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            trigger_pulse_out  <= 1'b0;
            trigger_source_out <= SRC_NONE;
            main_edge_input_count         <= '0;
        end else begin
            trigger_pulse_out <= arm && sel_ev;
            if (arm && sel_ev) begin
                trigger_source_out <= src_sel;
                main_edge_input_count         <= main_edge_input_count + 32'h0000_0001;
            end
        end
    end

    // Register read, data valid only in the cycle after the strobe
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_req_in.addr)
            REG_CTRL: begin
                rd_mux[CTRL_SRC_LSB +: 3] = src_sel;
                rd_mux[CTRL_MAIN_FALL]    = main_fall;
                rd_mux[CTRL_SYNC_FALL]    = sync_fall;
                rd_mux[CTRL_ARM]          = arm;
            end
            REG_TERM: begin
                rd_mux[TERM_MAIN] = main_termination_out;
                rd_mux[TERM_SYNC] = sync_termination_out;
            end
            REG_THRESH:    rd_mux[15:0]      = threshold_mv_out;
            REG_BP_DIR:    rd_mux[N_BP-1:0]  = bp_line_oe_out;
            REG_BP_MASK:   rd_mux[N_BP-1:0]  = bp_mask;
            REG_LVL_CTRL: begin
                rd_mux[LVL_CH_LSB +: 2] = lvl_ch;
                rd_mux[LVL_FALL]        = lvl_fall;
            end
            REG_LVL_CODE:  rd_mux[SMP_W-1:0] = lvl_code;
            REG_LVL_RESET: rd_mux[SMP_W-1:0] = lvl_reset;
            REG_PERIOD:    rd_mux            = period;
            REG_STATUS: begin
                rd_mux[2:0]                      = trigger_source_out;
                rd_mux[STAT_LVL_ARMED]           = lvl_armed;
                rd_mux[STAT_BP_OR]               = bp_or;
                rd_mux[STAT_PIN_LSB +: N_PIN]    = pin_lvl;
            end
            REG_COUNT:     rd_mux            = main_edge_input_count;
            default:       rd_mux            = '0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rd_en ? rd_mux : '0;
        end
    end

    // Checks
    a_sw_forward: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sw_ev && arm && src_sel == SRC_SOFTWARE |=> trigger_pulse_out)
        else $error("software trigger not forwarded");
    a_disarm_block: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !arm |=> !trigger_pulse_out)
        else $error("trigger forwarded while disarmed");
    a_main_edge: assert property (@(posedge clk_in) disable iff (!rstn_in)
        arm && src_sel == SRC_MAIN && !main_fall && pin_rise[0]
        |=> trigger_pulse_out && trigger_source_out == SRC_MAIN)
        else $error("main rising edge lost");
    a_sync_latency: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(s3[1]) && s2[1] |=> pin_lvl[1])
        else $error("sync edge not resolved in time");
    a_term_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_en && reg_req_in.addr == REG_TERM
        |=> main_termination_out == $past(reg_req_in.wdata[TERM_MAIN]))
        else $error("termination setting not taken");
    a_thresh_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_en && reg_req_in.addr == REG_THRESH
        |=> threshold_mv_out == $past(reg_req_in.wdata[15:0]))
        else $error("threshold not taken");
    a_bp_or: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (bp_lvl & bp_mask & ~bp_line_oe_out) != '0 |=> backplane_trigger_out)
        else $error("masked backplane line ignored");
    a_lvl_fire: assert property (@(posedge clk_in) disable iff (!rstn_in)
        samples_in.valid && prev_ok && lvl_armed && lvl_cross |=> lvl_ev ##1 !lvl_ev)
        else $error("level crossing missed");
    a_lvl_hyst: assert property (@(posedge clk_in) disable iff (!rstn_in)
        lvl_ev |-> !lvl_armed)
        else $error("level trigger not blocked after firing");
    a_per_spacing: assert property (@(posedge clk_in) disable iff (!rstn_in)
        per_ev && period > 32'h0000_0001 |=> !per_ev)
        else $error("periodic trigger too close");

    c_level: cover property (@(posedge clk_in) disable iff (!rstn_in)
        src_sel == SRC_LEVEL && trigger_pulse_out);
    c_periodic: cover property (@(posedge clk_in) disable iff (!rstn_in)
        src_sel == SRC_PERIODIC && trigger_pulse_out);
    c_backplane: cover property (@(posedge clk_in) disable iff (!rstn_in)
        src_sel == SRC_BACKPLANE && trigger_pulse_out);
    c_rearm: cover property (@(posedge clk_in) disable iff (!rstn_in)
        lvl_ev ##[1:50] lvl_armed);

endmodule

// ---- tb/main_edge_input_far_side.sv ----
// Far-side model: front panel sources, backplane equipment and sample stream
`timescale 1ns/1ns
module main_edge_input_far_side
    import main_edge_input_front_pkg::*;
(
    // Clock
    input  wire logic       clk_in,
    // Equipment levels and samples
    output logic            main_out,
    output logic            sync_out,
    output logic [N_BP-1:0] bp_drive_out,
    output sample_bus_type  samples_out
);
    initial begin
        main_out     = 1'b0;
        sync_out     = 1'b0;
        bp_drive_out = '0;
        samples_out  = '0;
    end

    // Pin 0 is the main input, pin 1 the sync input
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_in);
        if (idx == 0)
            main_out <= lvl;
        else
            sync_out <= lvl;
    endtask

    task automatic set_line(input int idx, input logic lvl);
        @(posedge clk_in);
        bp_drive_out[idx] <= lvl;
    endtask

    // One valid sample; data scrambled while not valid so stale values never look held
    task automatic send_sample(input int ch, input logic [SMP_W-1:0] code);
        @(posedge clk_in);
        samples_out.valid    <= 1'b1;
        samples_out.data[ch] <= code;
        @(posedge clk_in);
        samples_out.valid <= 1'b0;
        samples_out.data  <= ~samples_out.data;
    endtask
endmodule

// ---- tb/main_edge_input_front_end_test.sv ----
// Testbench for the trigger source front end
`timescale 1ns/1ns
module main_edge_input_front_end_test;
    import main_edge_input_front_pkg::*;
    logic              clk_in = 1'b0;
    logic              rstn_in = 1'b0;
    logic              main_edge_input_out_level = 1'b0;
    reg_req_type       req = '0;
    logic [DATA_W-1:0] rdata;
    logic              main_w;
    logic              sync_w;
    logic [N_BP-1:0]   bp_drive;
    logic [N_BP-1:0]   bp_out;
    logic [N_BP-1:0]   bp_oe;
    logic [N_BP-1:0]   bp_wire;
    sample_bus_type    smp;
    logic              pulse;
    logic              bp_main_edge_input;
    logic              term_m;
    logic              term_s;
    src_type           src;
    logic [15:0]       thr;
    int                n_mismatch = 0;
    int                n_compared = 0;
    int                n_pulse = 0;
    int                base = 0;
    shortint           rise[9] = '{0, 99, 100, 99, 100, 50, 99, 100, 100};
    shortint           fall[3] = '{0, -99, -100};
    int                lines[3] = '{0, 1, 5};

    always #10 clk_in = ~clk_in;
    // Driven lines carry the design level, the rest the equipment level
    assign bp_wire = (bp_oe & bp_out) | (~bp_oe & bp_drive);
    always @(posedge clk_in) if (pulse === 1'b1) n_pulse++;

    main_edge_input_front_end dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_req_in(req), .rdata_out(rdata),
        .main_edge_input_in(main_w), .sync_input_in(sync_w), .bp_line_in(bp_wire),
        .bp_line_out(bp_out), .bp_line_oe_out(bp_oe), .samples_in(smp),
        .main_edge_input_out_level_in(main_edge_input_out_level), .trigger_pulse_out(pulse),
        .trigger_source_out(src), .backplane_trigger_out(bp_main_edge_input),
        .main_termination_out(term_m), .sync_termination_out(term_s),
        .threshold_mv_out(thr)
    );

    main_edge_input_far_side far (
        .clk_in(clk_in), .main_out(main_w), .sync_out(sync_w),
        .bp_drive_out(bp_drive), .samples_out(smp)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                      input string what);
        @(posedge clk_in);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask

    // Pulses forwarded since the previous call
    task automatic pulses(input int exp, input string what);
        repeat (12) @(posedge clk_in);
        // Let the pulse counter and design outputs settle past the edge
        #1;
        check(n_pulse - base, exp, what);
        base = n_pulse;
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        results;
    end

    initial begin
        repeat (5) @(posedge clk_in);
        #1;
        check({term_s, term_m}, 2'b00, "termination at reset");
        check(thr, 16'h01F4, "threshold at reset");
        @(posedge clk_in) rstn_in <= 1'b1;
        rd(REG_THRESH, 32'h0000_01F4, "threshold register");
        rd(REG_PERIOD, PERIOD_RESET, "period register");
        rd(4'hC, 32'h0000_0000, "unmapped read");
        wr(4'hC, 32'hFFFF_FFFF);
        wr(REG_COUNT, 32'h0000_0055);
        rd(REG_COUNT, 32'h0000_0000, "count is read only");
        wr(REG_TERM, 32'h0000_0003);
        wr(REG_THRESH, 32'h0000_0320);
        repeat (2) @(posedge clk_in);
        #1;
        check({term_s, term_m}, 2'b11, "high impedance");
        check(thr, 16'h0320, "threshold written");
        rd(REG_TERM, 32'h0000_0003, "termination register");
        // Software source selected but disarmed
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_SW_MAIN_EDGE_INPUT, 32'h0000_0001);
        pulses(0, "disarmed software event");
        // Software source armed, one software event forwarded the cycle after the write
        wr(REG_CTRL, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0101);
        wr(REG_SW_MAIN_EDGE_INPUT, 32'h0000_0001);
        #1;
        check(pulse, 1'b1, "software pulse timing");
        check({29'h0, src}, 32'(SRC_SOFTWARE), "software source");
        pulses(1, "software pulse count");
        // Main then sync pin, rising then falling edge selection
        for (int k = 0; k < 2; k++) begin
            wr(REG_CTRL, 32'h0000_0102 + k);
            far.set_pin(1 - k, 1'b1);
            pulses(0, "unselected pin");
            far.set_pin(1 - k, 1'b0);
            far.set_pin(k, 1'b1);
            pulses(1, "rising edge");
            far.set_pin(k, 1'b0);
            pulses(0, "falling edge in rising mode");
            wr(REG_CTRL, (32'h0000_0102 + k) | (32'h0000_0010 << k));
            far.set_pin(k, 1'b1);
            pulses(0, "rising edge in falling mode");
            far.set_pin(k, 1'b0);
            pulses(1, "falling edge");
            check({29'h0, src}, 32'(2 + k), "pin source");
        end
        // Backplane: lines 2,3 outputs, mask covers an output line too
        wr(REG_BP_DIR, 32'h0000_000C);
        wr(REG_BP_MASK, 32'h0000_0027);
        wr(REG_CTRL, 32'h0000_0104);
        @(posedge clk_in) main_edge_input_out_level <= 1'b1;
        pulses(0, "output line not an input");
        check(bp_oe, 6'h0C, "direction");
        far.set_line(4, 1'b1);
        pulses(0, "unmasked line");
        check(bp_wire, 6'h1C, "outputs and inputs together");
        foreach (lines[i]) begin
            far.set_line(lines[i], 1'b1);
            pulses(1, "masked line");
            check(bp_main_edge_input, 1'b1, "backplane or");
            far.set_line(lines[i], 1'b0);
            pulses(0, "line released");
        end
        // Periodic every 4 samples, a whole number of data clocks
        wr(REG_PERIOD, 32'h0000_0004);
        wr(REG_CTRL, 32'h0000_0106);
        repeat (16) far.send_sample(0, 16'h0000);
        pulses(4, "periodic count");
        // Level on channel 2, code is baseline plus step
        wr(REG_LVL_CTRL, 32'h0000_0002);
        wr(REG_LVL_CODE, 32'h0000_0000 + 32'h0000_0064);
        wr(REG_LVL_RESET, 32'h0000_0032);
        wr(REG_CTRL, 32'h0000_0105);
        far.send_sample(0, 16'h00C8);
        pulses(0, "other channel");
        foreach (rise[i]) far.send_sample(2, rise[i]);
        pulses(2, "rising level with hysteresis");
        wr(REG_LVL_CTRL, 32'h0000_0012);
        wr(REG_LVL_CODE, 32'h0000_FF9C);
        wr(REG_LVL_RESET, 32'h0000_FFCE);
        foreach (fall[i]) far.send_sample(2, fall[i]);
        pulses(1, "falling level");
        // Last source level, hysteresis blocking, lines 2..4 high, masked OR low
        rd(REG_STATUS, 32'h0000_7005, "status after falling level");
        // 1 software, 4 pin, 3 backplane, 4 periodic, 3 level pulses
        rd(REG_COUNT, 32'h0000_000F, "forwarded count");
        results;
    end
endmodule
